// *** core/sbs_pkg.sv ***
// shared constants for the burst sram pin control block
`default_nettype none
package sbs_pkg;
  localparam int ADDR_W = 17;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int DATA_W = LANE_W * LANES;
  localparam int BURST_W = 2;
  localparam int SYNC_DEPTH = 3;
  localparam logic [BURST_W-1:0] BEAT_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BEAT_ONE = 2'h1;
  localparam logic [LANES-1:0] LANES_NONE = 4'hf;
  localparam logic [LANES-1:0] LANES_ALL = 4'h0;
  localparam logic [LANES-1:0] LANES_NARROW_MASK = 4'h3;
  typedef enum logic [1:0] {
    SBS_IDLE,
    SBS_READ,
    SBS_WRITE
  } sbs_cycle_t;
endpackage : sbs_pkg
`default_nettype wire

// *** core/sbs_pin_sync.sv ***
// three-stage synchroniser for asynchronous pins with agreement check
`timescale 1ns/1ps
`default_nettype none
module sbs_pin_sync (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic pin_i,
  output logic level_o
);
  import sbs_pkg::*;
  logic [SYNC_DEPTH-1:0] stage;
  // the first stage feeds only the second; level moves when 2 and 3 agree
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage <= '0;
    end else begin
      stage <= {stage[SYNC_DEPTH-2:0], pin_i};
    end
  end
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      level_o <= 1'b0;
    end else if (stage[1] == stage[2]) begin
      level_o <= stage[2];
    end
  end
endmodule : sbs_pin_sync
`default_nettype wire

// *** core/sbs_burst_cnt.sv ***
// two-bit burst address counter, linear or interleaved order
`timescale 1ns/1ps
`default_nettype none
module sbs_burst_cnt (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic load_i,
  input wire logic [sbs_pkg::BURST_W-1:0] start_i,
  input wire logic advance_i,
  input wire logic interleave_i,
  output logic [sbs_pkg::BURST_W-1:0] addr_o
);
  import sbs_pkg::*;
  logic [BURST_W-1:0] start;
  logic [BURST_W-1:0] beat;
  logic [BURST_W-1:0] next_beat;
  logic [BURST_W-1:0] cur_start;
  logic [BURST_W-1:0] cur_beat;
  // beat count wraps after four beats
  always_comb begin
    next_beat = beat + BEAT_ONE;
  end
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      start <= BEAT_ZERO;
      beat <= BEAT_ZERO;
    end else if (load_i) begin
      start <= start_i;
      beat <= BEAT_ZERO;
    end else if (advance_i) begin
      beat <= next_beat;
    end
  end
  // look ahead: the address of the edge being served, not of the last one
  always_comb begin
    cur_start = start;
    cur_beat = beat;
    if (load_i) begin
      cur_start = start_i;
      cur_beat = BEAT_ZERO;
    end else if (advance_i) begin
      cur_beat = next_beat;
    end
  end
  // linear adds the beat, interleaved xors it in
  always_comb begin
    addr_o = interleave_i ? (cur_start ^ cur_beat)
                          : (cur_start + cur_beat);
  end
endmodule : sbs_burst_cnt
`default_nettype wire

// *** core/sbs_sram_ctrl.sv ***
// pin control of a pipelined synchronous burst sram with its storage
// Functional notes
// - address captured when cache strobe low, or processor strobe with enable low
// - cache address strobe active low loads a new address
// - processor strobe ignored unless chip enable is low too
// - burst-advance low steps counter; high holds it
// - byte-write gate low passes lane enables; high blocks them
// - each lane enable governs one nine-bit lane, lowest first
// - any active lane write disables all data output drivers
// - selected only when enable low, select high high, select low low
// - global write low writes all four lanes (the lower two when narrow), overriding lane enables
// - write and read data registered on rising clock edges
// - burst-order select high interleaved, low linear
// - output enable low and selected drives pins; high floats them
// - sleep high stops internal clocking, contents kept
// - sleep input pulled down, so undriven means normal operation
// - narrow organisation ignores third and fourth lane enables
`timescale 1ns/1ps
`default_nettype none
module sbs_sram_ctrl #(
  parameter int ADDR_BITS = sbs_pkg::ADDR_W,
  parameter bit NARROW = 1'b0
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [ADDR_BITS-1:0] addr_i,
  input wire logic cache_addr_strobe_n_i,
  input wire logic proc_addr_strobe_n_i,
  input wire logic burst_advance_n_i,
  input wire logic byte_write_gate_n_i,
  input wire logic [sbs_pkg::LANES-1:0] lane_write_n_i,
  input wire logic all_lanes_write_n_i,
  input wire logic chip_en_n_i,
  input wire logic select_high_i,
  input wire logic select_low_n_i,
  input wire logic out_en_n_i,
  input wire logic burst_order_sel_i,
  input wire logic sleep_req_i,
  input wire logic [sbs_pkg::DATA_W-1:0] data_i,
  output logic [sbs_pkg::DATA_W-1:0] data_o,
  output logic [sbs_pkg::LANES-1:0] data_oe_o,
  output logic sleeping_o
);
  import sbs_pkg::*;
  localparam int DEPTH = 1 << ADDR_BITS;

  // storage is flip-flops; the depth is only practical for small widths
  initial begin
    if (ADDR_BITS <= BURST_W || ADDR_BITS > ADDR_W + 1) begin
      $error("sbs_sram_ctrl: ADDR_BITS out of range");
    end
  end

  // expand a per-lane mask to a per-bit mask
  function automatic logic [DATA_W-1:0] lane_bits(
    input logic [LANES-1:0] lanes
  );
    logic [DATA_W-1:0] bits;
    bits = '0;
    for (int i = 0; i < LANES; i++) begin
      bits[i*LANE_W +: LANE_W] = {LANE_W{lanes[i]}};
    end
    return bits;
  endfunction : lane_bits

  // asynchronous pins pass the three-stage synchroniser
  logic sleep_sync;
  logic oe_n_sync;
  logic order_sync;
  sbs_pin_sync u_sleep_sync (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .pin_i(sleep_req_i),
    .level_o(sleep_sync)
  );
  sbs_pin_sync u_oe_sync (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .pin_i(out_en_n_i),
    .level_o(oe_n_sync)
  );
  sbs_pin_sync u_order_sync (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .pin_i(burst_order_sel_i),
    .level_o(order_sync)
  );

  // sleep gates every state update but data_oe_o, sleeping_o and the synchronisers; a reset sync level of 0 acts as pull-down
  logic run;
  assign run = !sleep_sync;

  logic selected;
  logic cache_load;
  logic proc_load;
  logic load;
  logic [LANES-1:0] lanes_avail;
  logic [LANES-1:0] lane_req;
  logic any_write;
  assign selected = !chip_en_n_i && select_high_i && !select_low_n_i;
  assign cache_load = !cache_addr_strobe_n_i;
  assign proc_load = !proc_addr_strobe_n_i && !chip_en_n_i;
  assign load = run && (cache_load || proc_load) && selected;
  assign lanes_avail = NARROW ? LANES_NARROW_MASK : ~LANES_ALL;
  // global write wins; lane enables only count when the gate is low
  always_comb begin
    if (!all_lanes_write_n_i) begin
      lane_req = lanes_avail;
    end else if (!byte_write_gate_n_i) begin
      lane_req = ~lane_write_n_i & lanes_avail;
    end else begin
      lane_req = ~LANES_NONE;
    end
  end
  assign any_write = |lane_req;

  // address register, upper bits held across the burst
  logic [ADDR_BITS-1:0] addr_reg;
  logic active;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_reg <= '0;
    end else if (load) begin
      addr_reg <= addr_i;
    end
  end

  // a burst is live from a load until a deselected strobe
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      active <= 1'b0;
    end else if (run) begin
      if (load) begin
        active <= 1'b1;
      end else if ((cache_load || proc_load) && !selected) begin
        active <= 1'b0;
      end
    end
  end

  logic [BURST_W-1:0] beat_addr;
  sbs_burst_cnt u_burst (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .load_i(load),
    .start_i(addr_i[BURST_W-1:0]),
    .advance_i(run && !load && active && !burst_advance_n_i),
    .interleave_i(order_sync),
    .addr_o(beat_addr)
  );

  logic [ADDR_BITS-1:0] cur_addr;
  assign cur_addr = {addr_reg[ADDR_BITS-1:BURST_W], beat_addr};

  // write cycle registered at one edge is served at the next (pipeline stage); reads are served at the address edge
  sbs_cycle_t cycle;
  logic [ADDR_BITS-1:0] cyc_addr;
  logic [LANES-1:0] cyc_lanes;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cycle <= SBS_IDLE;
      cyc_addr <= '0;
      cyc_lanes <= '0;
    end else if (run) begin
      cyc_addr <= load ? addr_i : cur_addr;
      cyc_lanes <= lane_req;
      if (load || (active && !burst_advance_n_i)) begin
        cycle <= any_write ? SBS_WRITE : SBS_READ;
      end else if (load == 1'b0 && !active) begin
        cycle <= SBS_IDLE;
      end else begin
        cycle <= any_write ? SBS_WRITE : SBS_READ;
      end
    end
  end

  // write data taken straight from data_i at the serving edge and committed per lane
  logic [DATA_W-1:0] wr_data;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_data <= '0;
    end else if (run) begin
      wr_data <= data_i;
    end
  end

  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] wmask;
  assign wmask = lane_bits(cyc_lanes);
  always_ff @(posedge clk_sys_i) begin
    if (run && cycle == SBS_WRITE) begin
      mem[cyc_addr] <= (mem[cyc_addr] & ~wmask) | (data_i & wmask);
    end
  end

  // read data registered at the address edge itself, so it appears right after that edge
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_o <= '0;
    end else if (run) begin
      data_o <= mem[load ? addr_i : cur_addr];
    end
  end

  // drivers: selected burst, output enable low, no lane write this edge
  logic drive;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      drive <= 1'b0;
    end else if (run) begin
      drive <= (load || active) && !any_write;
    end
  end
  // output enable is a pin, so it reaches us through the synchroniser
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_oe_o <= '0;
    end else begin
      data_oe_o <= {LANES{drive && !oe_n_sync && !any_write}};
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sleeping_o <= 1'b0;
    end else begin
      sleeping_o <= sleep_sync;
    end
  end

  // checks
  a_proc_gated: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (chip_en_n_i && cache_addr_strobe_n_i) |-> !load)
    else $error("processor strobe loaded without chip enable");
  a_select_needed: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    load |-> (select_high_i && !select_low_n_i && !chip_en_n_i))
    else $error("load while not selected");
  a_addr_capture: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    load |=> addr_reg == $past(addr_i))
    else $error("address not captured");
  a_burst_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (!load && burst_advance_n_i) ##1 (!load && burst_advance_n_i)
    |-> $stable(beat_addr))
    else $error("burst counter moved without advance");
  a_write_float: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    any_write |=> data_oe_o == '0)
    else $error("drivers on during a lane write");
  a_oe_float: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    oe_n_sync |=> data_oe_o == '0)
    else $error("drivers on with output enable high");
  a_global_all: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !all_lanes_write_n_i |-> lane_req == lanes_avail)
    else $error("global write missed lanes");
  a_gate_block: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (all_lanes_write_n_i && byte_write_gate_n_i) |-> !any_write)
    else $error("lane write passed with gate high");
  a_sleep_freeze: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sleep_sync |=> $stable(addr_reg) && $stable(data_o))
    else $error("state changed in sleep");
  a_narrow_lanes: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    NARROW |-> lane_req[LANES-1:2] == '0)
    else $error("upper lanes active in narrow mode");

  // a selected cache strobe while awake must load
  a_cache_load: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (run && selected && !cache_addr_strobe_n_i) |-> load)
    else $error("cache strobe did not load");
  // a selected processor strobe while awake must load
  a_proc_load: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (run && selected && !proc_addr_strobe_n_i) |-> load)
    else $error("processor strobe did not load");
  // nothing is taken while the clock is gated
  a_sleep_noload: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sleep_sync |-> !load)
    else $error("load taken while sleeping");
  // the sleep flag follows the synchronised pin one edge later
  a_sleep_flag: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sleep_sync |=> sleeping_o)
    else $error("sleep flag not raised");

  // a selected read with output enable low turns every lane on
  a_oe_drive: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (drive && !oe_n_sync && !any_write) |=> data_oe_o == '1)
    else $error("drivers off for an enabled read");
  // lane enables pass lane by lane when the gate is open
  a_lane_pass: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (all_lanes_write_n_i && !byte_write_gate_n_i)
    |-> lane_req == (~lane_write_n_i & lanes_avail))
    else $error("lane enables not passed");

  // a cache strobe while deselected ends the burst
  a_deselect_end: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (run && cache_load && !selected) |=> !active)
    else $error("burst kept after deselected strobe");
  // no burst, no drivers two edges on
  a_idle_float: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (run && !active && !load) |=> ##1 data_oe_o == '0)
    else $error("drivers on while not selected");
endmodule : sbs_sram_ctrl
`default_nettype wire

// *** dv/sbs_bus_master.sv ***
// cache controller model driving the synchronous burst bus
`timescale 1ns/1ps
`default_nettype none
module sbs_bus_master #(
  parameter int AW = 6
) (
  input wire logic clk_sys_i,
  output logic [AW-1:0] addr_o,
  output logic cstb_n_o,
  output logic pstb_n_o,
  output logic en_n_o,
  output logic step_n_o,
  output logic all_n_o,
  output logic gate_n_o,
  output logic [3:0] lane_n_o,
  output logic [35:0] wdata_o
);
  // idle bus: strobes off, lanes off
  initial begin
    {cstb_n_o, pstb_n_o, en_n_o, step_n_o, all_n_o, gate_n_o} = 6'h3f;
    lane_n_o = 4'hf;
    addr_o = '0;
    wdata_o = 36'h0;
  end
  // one cycle: launch after the falling edge, hold to the rising edge;
  // undriven data toggles so a stale value never looks valid
  task cyc(input logic [5:0] c, input logic [3:0] ln,
           input logic [AW-1:0] a, input logic [35:0] d, input logic dv);
    @(negedge clk_sys_i);
    {cstb_n_o, pstb_n_o, en_n_o, step_n_o, all_n_o, gate_n_o} <= c;
    lane_n_o <= ln;
    addr_o <= a;
    wdata_o <= dv ? d : ~wdata_o;
    @(posedge clk_sys_i);
  endtask : cyc
endmodule : sbs_bus_master
`default_nettype wire

// *** dv/tb_sbs_sram_ctrl.sv ***
// self-checking bench for the burst sram pin control
`timescale 1ns/1ps
`default_nettype none
module tb_sbs_sram_ctrl;
  import sbs_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic sel_hi = 1'b1;
  logic sel_lo_n = 1'b0;
  logic oe_n = 1'b0;
  logic order = 1'b0;
  logic sleep = 1'b0;
  logic [5:0] addr;
  logic cstb_n, pstb_n, en_n, step_n, all_n, gate_n;
  logic [3:0] lane_n;
  logic [DATA_W-1:0] wdata, rdata, e8;
  logic [LANES-1:0] oe;
  logic slp;
  int error_cnt = 0;
  int total_checks = 0;

  // 25 MHz clock
  always #20 clk_sys_i = ~clk_sys_i;

  sbs_bus_master #(.AW(6)) u_sbs_bus_master (.clk_sys_i(clk_sys_i),
    .addr_o(addr), .cstb_n_o(cstb_n), .pstb_n_o(pstb_n), .en_n_o(en_n),
    .step_n_o(step_n), .all_n_o(all_n), .gate_n_o(gate_n),
    .lane_n_o(lane_n), .wdata_o(wdata));

  sbs_sram_ctrl #(.ADDR_BITS(6), .NARROW(1'b0)) u_sbs_sram_ctrl (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr),
    .cache_addr_strobe_n_i(cstb_n), .proc_addr_strobe_n_i(pstb_n),
    .burst_advance_n_i(step_n), .byte_write_gate_n_i(gate_n),
    .lane_write_n_i(lane_n), .all_lanes_write_n_i(all_n),
    .chip_en_n_i(en_n), .select_high_i(sel_hi), .select_low_n_i(sel_lo_n),
    .out_en_n_i(oe_n), .burst_order_sel_i(order), .sleep_req_i(sleep),
    .data_i(wdata), .data_o(rdata), .data_oe_o(oe), .sleeping_o(slp));

  function automatic logic [DATA_W-1:0] pat(input logic [5:0] a);
    return 36'h9a5c3e100 ^ {30'h0, a};
  endfunction : pat

  task finish_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task chk_d(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %0t data %h expected %h", $time, g, e);
    end
  endtask : chk_d

  task chk_v(input logic [3:0] g, input logic [3:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %0t flags %h expected %h", $time, g, e);
    end
  endtask : chk_v

  // idle cycle, s low steps the burst
  task nop(input logic s);
    u_sbs_bus_master.cyc(s ? 6'h37 : 6'h33, 4'hf, '0, '0, 1'b0);
  endtask : nop

  // look at read data once the edge has settled
  task look(input logic [DATA_W-1:0] e);
    #1 chk_d(rdata, e);
  endtask : look

  // address phase, then data phase one edge later
  task wr(input logic [5:0] c, input logic [3:0] ln, input logic [5:0] a,
          input logic [DATA_W-1:0] d);
    u_sbs_bus_master.cyc(c, ln, a, '0, 1'b0);
    u_sbs_bus_master.cyc(6'h37, 4'hf, '0, d, 1'b1);
  endtask : wr

  task rst;
    @(negedge clk_sys_i);
    rstn_i = 1'b0;
    repeat (8) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    repeat (5) nop(1'b1);
  endtask : rst

  task t_write;
    for (int i = 0; i < 4; i++)
      wr(6'h15, 4'ha, 6'h10 + 6'(i), pat(6'h10 + 6'(i)));
    wr(6'h15, 4'ha, 6'h08, pat(6'h08));
    #1 chk_v(oe, 4'h0);
    u_sbs_bus_master.cyc(6'h17, 4'hf, 6'h08, '0, 1'b0);
    nop(1'b1);
    look(pat(6'h08));
    nop(1'b1);
    #1 chk_v(oe, 4'hf);
    wr(6'h16, 4'he, 6'h08, ~pat(6'h08));
    #1 chk_v(oe, 4'h0);
    wr(6'h17, 4'h0, 6'h08, 36'h0);
    e8 = pat(6'h08);
    e8[8:0] = ~e8[8:0];
    u_sbs_bus_master.cyc(6'h17, 4'hf, 6'h08, '0, 1'b0);
    nop(1'b1);
    look(e8);
  endtask : t_write

  // beats seen after each edge: 0, then 1,1,2,3,0 (second step held)
  task t_burst;
    logic [1:0] b;
    u_sbs_bus_master.cyc(6'h17, 4'hf, 6'h11, '0, 1'b0);
    look(pat({4'h4, order ? 2'h1 : 2'h1}));
    for (int i = 0; i < 5; i++) begin
      nop(i == 1);
      b = 2'(i + 1 - (i > 0));
      look(pat({4'h4, order ? 2'h1 ^ b : 2'h1 + b}));
    end
  endtask : t_burst

  task t_refuse;
    u_sbs_bus_master.cyc(6'h2f, 4'hf, 6'h08, '0, 1'b0);
    nop(1'b1);
    look(pat(6'h11));
    u_sbs_bus_master.cyc(6'h27, 4'hf, 6'h08, '0, 1'b0);
    nop(1'b1);
    look(e8);
    @(negedge clk_sys_i);
    sel_hi = 1'b0;
    u_sbs_bus_master.cyc(6'h17, 4'hf, 6'h11, '0, 1'b0);
    repeat (3) nop(1'b1);
    #1 chk_v(oe, 4'h0);
    @(negedge clk_sys_i);
    sel_hi = 1'b1;
    repeat (2) nop(1'b1);
    look(e8);
  endtask : t_refuse

  task t_sleep;
    @(negedge clk_sys_i);
    sleep = 1'b1;
    repeat (5) nop(1'b1);
    #1 chk_v({3'h0, slp}, 4'h1);
    u_sbs_bus_master.cyc(6'h17, 4'hf, 6'h11, '0, 1'b0);
    @(negedge clk_sys_i);
    sleep = 1'b0;
    repeat (5) nop(1'b1);
    look(e8);
    u_sbs_bus_master.cyc(6'h17, 4'hf, 6'h11, '0, 1'b0);
    nop(1'b1);
    look(pat(6'h11));
  endtask : t_sleep

  // order pin only moves just before a reset, which then restarts the block
  initial begin
    rst();
    t_write();
    t_burst();
    t_refuse();
    t_sleep();
    order = 1'b1;
    rst();
    t_burst();
    finish_test();
  end

  // watchdog: the sequence needs under a hundred cycles, the limit is 2000
  initial begin
    #80000;
    error_cnt++;
    finish_test();
  end
endmodule : tb_sbs_sram_ctrl
`default_nettype wire
